//--- brs_pkg.sv
package brs_pkg;

   localparam logic [7:0] BRS_ADDR_BOOST = 8'h00;
   localparam logic [7:0] BRS_ADDR_IO = 8'h02;
   localparam logic [7:0] BRS_ADDR_CORE = 8'h03;
   localparam logic [7:0] BRS_ADDR_GH_COLD = 8'h04;
   localparam logic [7:0] BRS_ADDR_GH_HOT = 8'h05;
   localparam logic [7:0] BRS_ADDR_DLY_FIRST = 8'h07;
   localparam logic [7:0] BRS_ADDR_LAST = 8'h09;
   localparam logic [7:0] BRS_ADDR_CTL = 8'hff;

   localparam logic [5:0] BRS_DEV_ADDR_HI = 6'h10;
   localparam int BRS_CTL_STORE_BIT = 7;
   localparam int BRS_CTL_SRC_BIT = 0;
   localparam logic [3:0] BRS_BYTE_BITS = 4'h8;
   localparam logic [3:0] BRS_LAST_BIT = 4'h7;

   // Writable bits of each setting register, index 9 first
   localparam logic [9:0][7:0] BRS_FIELD_MASK = {
      8'h07, 8'h07, 8'h07, 8'h3f, 8'h0f, 8'h0f, 8'h0f, 8'h07, 8'h3f, 8'h3f};

   localparam logic [7:0] BRS_SETTING_RESET = 8'h00;
   localparam logic BRS_SRC_RESET = 1'b0;

   typedef enum logic [2:0] {
      BRS_ST_IDLE = 3'b000,
      BRS_ST_RX = 3'b001,
      BRS_ST_ACK = 3'b010,
      BRS_ST_TX = 3'b011,
      BRS_ST_TXACK = 3'b100
   } brs_state_type;

   typedef logic [9:0][7:0] brs_bank_type;

   typedef struct packed {
      logic [7:0] seq_delay_third;
      logic [7:0] seq_delay_second;
      logic [7:0] seq_delay_first;
      logic [7:0] gate_low_level;
      logic [7:0] gate_high_hot_level;
      logic [7:0] gate_high_cold_level;
      logic [7:0] core_rail_level;
      logic [7:0] io_rail_level;
      logic [7:0] source_rail_level;
      logic [7:0] boost_rail_level;
   } brs_settings_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } brs_twi_in_type;

endpackage

//--- brs_setting_store.sv
module brs_setting_store (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire brs_pkg::brs_twi_in_type twi,
   input wire logic addr_select_pin,
   output brs_pkg::brs_settings_type rail_settings,
   output logic setting_load,
   output logic store_pulse,
   output logic readback_source_select,
   output logic sda_out,
   output logic sda_oe
);
   import brs_pkg::*;

   typedef struct packed {
      brs_state_type state;
      logic scl_q;
      logic sda_q;
      logic [3:0] bit_cnt;
      logic [1:0] byte_idx;
      logic rw;
      logic m_ack;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic src_sel;
      logic store_pulse;
      logic load_pulse;
      logic ctl_wr;
      logic sda_oe;
      logic sda_out;
      brs_bank_type live;
      brs_bank_type nv;
   } brs_core_type;

   brs_core_type s_r;
   brs_core_type s_nxt;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rd_byte;

   // Byte the read would return for the current pointer and source
   always_comb begin
      rd_byte = 8'h00;
      if (s_r.ptr == BRS_ADDR_CTL) begin
         rd_byte = {7'h00, s_r.src_sel};
      end else if (s_r.ptr <= BRS_ADDR_LAST) begin
         // Narrow fields were masked on write, so upper bits are zero
         rd_byte = s_r.src_sel ? s_r.nv[s_r.ptr[3:0]] : s_r.live[s_r.ptr[3:0]];
      end
   end

   assign scl_rise = twi.scl & ~s_r.scl_q;
   assign scl_fall = ~twi.scl & s_r.scl_q;
   assign start_cond = s_r.scl_q & twi.scl & s_r.sda_q & ~twi.sda;
   assign stop_cond = s_r.scl_q & twi.scl & ~s_r.sda_q & twi.sda;

   always_comb begin
      s_nxt = s_r;
      s_nxt.store_pulse = 1'b0;
      s_nxt.load_pulse = 1'b0;
      s_nxt.ctl_wr = 1'b0;
      s_nxt.scl_q = twi.scl;
      s_nxt.sda_q = twi.sda;
      if (stop_cond) begin
         s_nxt.state = BRS_ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else if (start_cond) begin
         // Repeated START keeps the pointer so a read follows the pointer write
         s_nxt.state = BRS_ST_RX;
         s_nxt.bit_cnt = 4'h0;
         s_nxt.byte_idx = 2'd0;
         s_nxt.sda_oe = 1'b0;
      end else begin
         unique case (s_r.state)
            BRS_ST_IDLE: begin
            end
            BRS_ST_RX: begin
               if (scl_rise && s_r.bit_cnt < BRS_BYTE_BITS) begin
                  s_nxt.shreg = {s_r.shreg[6:0], twi.sda};
                  s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               end else if (scl_fall && s_r.bit_cnt == BRS_BYTE_BITS) begin
                  s_nxt.bit_cnt = 4'h0;
                  if (s_r.byte_idx == 2'd0) begin
                     if (s_r.shreg[7:1] == {BRS_DEV_ADDR_HI, addr_select_pin}) begin
                        s_nxt.rw = s_r.shreg[0];
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.state = BRS_ST_ACK;
                        s_nxt.byte_idx = 2'd1;
                     end else begin
                        s_nxt.state = BRS_ST_IDLE;
                     end
                  end else begin
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.state = BRS_ST_ACK;
                     if (s_r.byte_idx == 2'd1) begin
                        s_nxt.ptr = s_r.shreg;
                        s_nxt.byte_idx = 2'd2;
                     end else if (s_r.ptr <= BRS_ADDR_LAST) begin
                        // Extra data bytes rewrite the same register; no auto-increment
                        s_nxt.live[s_r.ptr[3:0]] =
                           s_r.shreg & BRS_FIELD_MASK[s_r.ptr[3:0]];
                        s_nxt.load_pulse = 1'b1;
                     end else if (s_r.ptr == BRS_ADDR_CTL) begin
                        s_nxt.src_sel = s_r.shreg[BRS_CTL_SRC_BIT];
                        s_nxt.ctl_wr = 1'b1;
                        if (s_r.shreg[BRS_CTL_STORE_BIT]) begin
                           s_nxt.nv = s_r.live;
                           s_nxt.store_pulse = 1'b1;
                        end
                     end
                  end
               end
            end
            BRS_ST_ACK: begin
               if (scl_fall) begin
                  s_nxt.bit_cnt = 4'h0;
                  if (s_r.rw) begin
                     s_nxt.state = BRS_ST_TX;
                     s_nxt.shreg = rd_byte;
                     s_nxt.sda_oe = ~rd_byte[7];
                  end else begin
                     s_nxt.state = BRS_ST_RX;
                     s_nxt.sda_oe = 1'b0;
                  end
               end
            end
            BRS_ST_TX: begin
               if (scl_fall) begin
                  if (s_r.bit_cnt == BRS_LAST_BIT) begin
                     s_nxt.state = BRS_ST_TXACK;
                     s_nxt.sda_oe = 1'b0;
                  end else begin
                     s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                     s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                     s_nxt.sda_oe = ~s_r.shreg[6];
                  end
               end
            end
            BRS_ST_TXACK: begin
               if (scl_rise) begin
                  s_nxt.m_ack = ~twi.sda;
               end else if (scl_fall) begin
                  // A master that acks anyway gets the same register again
                  if (s_r.m_ack) begin
                     s_nxt.state = BRS_ST_TX;
                     s_nxt.bit_cnt = 4'h0;
                     s_nxt.shreg = rd_byte;
                     s_nxt.sda_oe = ~rd_byte[7];
                  end else begin
                     s_nxt.state = BRS_ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.state = BRS_ST_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r.state <= BRS_ST_IDLE;
         s_r.scl_q <= 1'b1;
         s_r.sda_q <= 1'b1;
         s_r.bit_cnt <= 4'h0;
         s_r.byte_idx <= 2'd0;
         s_r.rw <= 1'b0;
         s_r.m_ack <= 1'b0;
         s_r.shreg <= 8'h00;
         s_r.ptr <= 8'h00;
         s_r.src_sel <= BRS_SRC_RESET;
         s_r.store_pulse <= 1'b0;
         s_r.load_pulse <= 1'b0;
         s_r.ctl_wr <= 1'b0;
         s_r.sda_oe <= 1'b0;
         s_r.sda_out <= 1'b0;
         s_r.live <= {10{BRS_SETTING_RESET}};
         s_r.nv <= {10{BRS_SETTING_RESET}};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign rail_settings = brs_settings_type'(s_r.live);
   assign setting_load = s_r.load_pulse;
   assign store_pulse = s_r.store_pulse;
   assign readback_source_select = s_r.src_sel;
   assign sda_out = s_r.sda_out;
   assign sda_oe = s_r.sda_oe;

   AST_STORE_ALL: assert property (@(posedge mclk) disable iff (rst)
      s_r.store_pulse |-> s_r.nv == s_r.live)
      else $error("store did not copy every setting");

   AST_STORE_ONCE: assert property (@(posedge mclk) disable iff (rst)
      (s_r.store_pulse && ce) |=> !s_r.store_pulse)
      else $error("store trigger repeated");

   AST_STORE_CAUSE: assert property (@(posedge mclk) disable iff (rst)
      $rose(s_r.store_pulse) |-> s_r.ctl_wr && $past(s_r.shreg[7]))
      else $error("store without a control write of the store bit");

   AST_SRC_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !$stable(s_r.src_sel) |-> s_r.ctl_wr)
      else $error("source select changed without control write");

   AST_LOAD_DATA: assert property (@(posedge mclk) disable iff (rst)
      $rose(s_r.load_pulse) |->
         s_r.live[s_r.ptr[3:0]] == ($past(s_r.shreg) & BRS_FIELD_MASK[s_r.ptr[3:0]]))
      else $error("setting register not loaded from data byte");

   AST_ACK_DRIVE: assert property (@(posedge mclk) disable iff (rst)
      (s_r.state == BRS_ST_ACK) |-> s_r.sda_oe)
      else $error("acknowledge slot not driven low");

   AST_READ_BYTE: assert property (@(posedge mclk) disable iff (rst)
      (s_r.state == BRS_ST_TX && $past(s_r.state) == BRS_ST_ACK) |->
         s_r.shreg == $past(rd_byte) && s_r.sda_oe == ~s_r.shreg[7])
      else $error("read byte not loaded from selected source");

   AST_TX_RELEASE: assert property (@(posedge mclk) disable iff (rst)
      (s_r.state == BRS_ST_TXACK) |-> !s_r.sda_oe)
      else $error("data line driven during master acknowledge");

   AST_NARROW: assert property (@(posedge mclk) disable iff (rst)
      s_r.live[4][7:4] == 4'h0 && s_r.live[5][7:4] == 4'h0 && s_r.live[3][7:4] == 4'h0 &&
      s_r.live[2][7:3] == 5'h00 && s_r.live[7][7:3] == 5'h00 &&
      s_r.live[8][7:3] == 5'h00 && s_r.live[9][7:3] == 5'h00)
      else $error("unused setting bits not zero");

   AST_ADDR_MATCH: assert property (@(posedge mclk) disable iff (rst)
      (s_r.state == BRS_ST_ACK && $past(s_r.state) == BRS_ST_RX &&
         $past(s_r.byte_idx) == 2'd0) |->
         $past(s_r.shreg[7:1]) == {BRS_DEV_ADDR_HI, $past(addr_select_pin)})
      else $error("acknowledged a foreign device address");

   // A foreign address must leave the line alone so another device can answer
   AST_ADDR_REFUSE: assert property (@(posedge mclk) disable iff (rst)
      (ce && s_r.state == BRS_ST_RX && s_r.byte_idx == 2'd0 && scl_fall &&
         s_r.bit_cnt == BRS_BYTE_BITS && s_r.shreg[7:1] != {BRS_DEV_ADDR_HI, addr_select_pin})
         |=> (s_r.state == BRS_ST_IDLE && !s_r.sda_oe))
      else $error("foreign device address not ignored");

   AST_ACK_SLOT: assert property (@(posedge mclk) disable iff (rst)
      (ce && s_r.state == BRS_ST_RX && s_r.byte_idx != 2'd0 && scl_fall &&
         s_r.bit_cnt == BRS_BYTE_BITS) |=> (s_r.state == BRS_ST_ACK && s_r.sda_oe))
      else $error("received byte not acknowledged");

   AST_ACK_RELEASE: assert property (@(posedge mclk) disable iff (rst)
      (ce && s_r.state == BRS_ST_ACK && !s_r.rw && scl_fall) |=>
         (s_r.state == BRS_ST_RX && !s_r.sda_oe))
      else $error("data line held after acknowledge slot");

   AST_SRC_WRITE: assert property (@(posedge mclk) disable iff (rst)
      $rose(s_r.ctl_wr) |-> s_r.src_sel == $past(s_r.shreg[BRS_CTL_SRC_BIT]))
      else $error("source select not taken from the control byte");

   // Covers the stored copy too, since the masks are applied only on write
   AST_READ_NARROW: assert property (@(posedge mclk) disable iff (rst)
      (s_r.ptr <= BRS_ADDR_LAST) |-> (rd_byte & ~BRS_FIELD_MASK[s_r.ptr[3:0]]) == 8'h00)
      else $error("unused read bits not zero");

   AST_TX_BIT: assert property (@(posedge mclk) disable iff (rst)
      (s_r.state == BRS_ST_TX) |-> s_r.sda_oe == ~s_r.shreg[7])
      else $error("read bit on the line differs from the shifted byte");

   AST_TXACK_END: assert property (@(posedge mclk) disable iff (rst)
      (ce && s_r.state == BRS_ST_TXACK && scl_fall && !s_r.m_ack) |=>
         (s_r.state == BRS_ST_IDLE && !s_r.sda_oe))
      else $error("read not ended after master refusal");

   // Settings drive the converters directly, so a stray change would move a rail
   AST_LIVE_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !$stable(s_r.live) |-> (s_r.load_pulse && s_r.ptr <= BRS_ADDR_LAST))
      else $error("setting changed without a data byte");

   AST_NV_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !$stable(s_r.nv) |-> s_r.store_pulse)
      else $error("stored copy changed without a store command");

   AST_STOP_IDLE: assert property (@(posedge mclk) disable iff (rst)
      (ce && stop_cond) |=> (s_r.state == BRS_ST_IDLE && !s_r.sda_oe))
      else $error("stop condition did not end the transaction");

endmodule

//--- brs_twi_master.sv
module brs_twi_master (
   input wire logic mclk,
   input wire logic sda_bus,
   output logic scl,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idles released; the pull-up makes an undriven line read high
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Also serves as repeated start: sda is raised while scl is still low
   task automatic start_cond();
      sda_drv = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(3);
      sda_drv = 1'b0;
      hold(3);
      scl = 1'b0;
      hold(2);
   endtask

   task automatic stop_cond();
      sda_drv = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(3);
      sda_drv = 1'b1;
      hold(3);
   endtask

   // Data changes only while scl is low, sampled mid-way through scl high
   task automatic bit_cycle(input logic b, output logic s);
      sda_drv = b;
      hold(2);
      scl = 1'b1;
      hold(2);
      s = sda_bus;
      hold(2);
      scl = 1'b0;
      hold(2);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask

   task automatic get_byte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(1'b1, s);
   endtask
endmodule

//--- test_bias_rail_setting_store.sv
module test_bias_rail_setting_store;
   timeunit 1ns;
   timeprecision 1ps;
   import brs_pkg::*;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic addr_select_pin = 1'b1;
   logic scl, sda_m, sda_out, sda_oe, setting_load, store_pulse, src_sel, ack;
   logic [7:0] rd;
   brs_settings_type rails;
   brs_bank_type bank;
   brs_twi_in_type twi;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int stores = 0;
   int loads = 0;

   assign twi.scl = scl;
   // The open-drain low value comes from the design, not from the bench
   assign twi.sda = sda_m & (~sda_oe | sda_out);
   assign bank = rails;

   always #25 mclk = ~mclk;

   brs_twi_master mst_u (.mclk(mclk), .sda_bus(twi.sda), .scl(scl), .sda_drv(sda_m));

   brs_setting_store dut_u (.mclk(mclk), .rst(rst), .ce(ce), .twi(twi),
      .addr_select_pin(addr_select_pin), .rail_settings(rails), .setting_load(setting_load),
      .store_pulse(store_pulse), .readback_source_select(src_sel),
      .sda_out(sda_out), .sda_oe(sda_oe));

   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Whole run needs roughly 13k cycles
   // Pulses are counted on the falling edge, where they stand settled
   always @(negedge mclk) begin
      cycles++;
      if (store_pulse === 1'b1) begin
         stores++;
      end
      if (setting_load === 1'b1) begin
         loads++;
      end
      if (cycles == 40000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic put_acked(input logic [7:0] d);
      mst_u.put_byte(d, ack);
      check("byte ack", 8'h01, {7'h00, ack});
   endtask

   // One register per START..STOP transaction, no burst
   task automatic wr(input logic [7:0] ra, input logic [7:0] d);
      mst_u.start_cond();
      put_acked({BRS_DEV_ADDR_HI, addr_select_pin, 1'b0});
      put_acked(ra);
      put_acked(d);
      mst_u.stop_cond();
   endtask

   task automatic rd_reg(input logic [7:0] ra, output logic [7:0] d);
      mst_u.start_cond();
      put_acked({BRS_DEV_ADDR_HI, addr_select_pin, 1'b0});
      put_acked(ra);
      mst_u.start_cond();
      put_acked({BRS_DEV_ADDR_HI, addr_select_pin, 1'b1});
      mst_u.get_byte(d);
      mst_u.stop_cond();
   endtask

   initial begin
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      mst_u.hold(2);
      for (int i = 0; i <= 9; i++) begin
         wr(i[7:0], 8'hff);
         check("live field", BRS_FIELD_MASK[i], bank[i]);
      end
      check("load count", 8'h0a, loads[7:0]);
      wr(BRS_ADDR_CTL, 8'h00);
      check("source", 8'h00, {7'h00, src_sel});
      for (int i = 0; i <= 9; i++) begin
         rd_reg(i[7:0], rd);
         check("live read", BRS_FIELD_MASK[i], rd);
      end
      wr(BRS_ADDR_CTL, 8'h80);
      check("store count", 8'h01, stores[7:0]);
      for (int i = 0; i <= 9; i++) begin
         wr(i[7:0], 8'h00);
      end
      check("store repeat", 8'h01, stores[7:0]);
      wr(BRS_ADDR_CTL, 8'h01);
      check("source", 8'h01, {7'h00, src_sel});
      for (int i = 0; i <= 9; i++) begin
         rd_reg(i[7:0], rd);
         check("stored read", BRS_FIELD_MASK[i], rd);
      end
      wr(BRS_ADDR_CORE, 8'h0a);
      check("core live", 8'h0a, bank[3]);
      check("source held", 8'h01, {7'h00, src_sel});
      rd_reg(BRS_ADDR_CORE, rd);
      check("core stored", 8'h0f, rd);
      rd_reg(BRS_ADDR_CTL, rd);
      check("source read", 8'h01, rd);
      // Pin low: the old address must now be ignored
      addr_select_pin = 1'b0;
      mst_u.start_cond();
      mst_u.put_byte({BRS_DEV_ADDR_HI, 1'b1, 1'b0}, ack);
      check("foreign addr", 8'h00, {7'h00, ack});
      mst_u.stop_cond();
      wr(BRS_ADDR_GH_HOT, 8'h05);
      check("hot live", 8'h05, bank[5]);
      summarize();
   end
endmodule
